// >>> rrsb_pkg.sv
// constants, field layout and state codes of the rotate/subtract datapath slice
// What this block does
// - rotate right to work: memory bit 0 lands in bit 7, flags untouched
// - rotate memory right through carry: old carry to bit 7, bit 0 to carry
// - same carry rotate, result to work register, memory byte left alone
// - work register gets work minus memory byte minus inverted carry
// - same difference written to the addressed memory byte instead
// - subtract clears carry on negative difference, sets it on zero or positive
// - subtract updates all six flags; rotates touch only carry where stated
package rrsb_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W = 8;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int FLAG_W = 6;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_WORK = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_MADDR = 8'h0c;
  localparam logic [7:0] OFS_MDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // ==========================================================
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int CMD_ADDR_LSB = 4;
  // ==========================================================
  // flag bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_ZERO = 1;
  localparam int FLG_NIBBLE = 2;
  localparam int FLG_WRAP = 3;
  localparam int FLG_SIGN = 4;
  localparam int FLG_CHAIN = 5;
  // ==========================================================
  // reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [3:0] MADDR_RST = 4'h0;
  localparam logic [2:0] OP_NONE = 3'h7;
  // ==========================================================
  // operation codes
  localparam logic [2:0] OP_ROT_WORK = 3'h0;
  localparam logic [2:0] OP_ROTB_MEM = 3'h1;
  localparam logic [2:0] OP_ROTB_WORK = 3'h2;
  localparam logic [2:0] OP_SUBB_WORK = 3'h3;
  localparam logic [2:0] OP_SUBB_MEM = 3'h4;
  // ==========================================================
  // bus encodings and sequencer state codes
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEMRD = 3'b010,
    ST_EXEC = 3'b100
  } rrsb_state_t;
endpackage

// >>> rrsb_mem.sv
// small data memory with registered read data
`timescale 1ns/1ps
module rrsb_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [rrsb_pkg::MEM_AW-1:0] addr,
  input wire logic we,
  input wire logic [rrsb_pkg::DATA_W-1:0] wdata,
  output logic [rrsb_pkg::DATA_W-1:0] rdata
);
  logic [rrsb_pkg::DATA_W-1:0] mem_r [rrsb_pkg::MEM_DEPTH];

  // ==========================================================
  // storage, read first: on a same-cycle write, read shows old contents
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= mem_r[addr];
    end
  end
endmodule

// >>> rrsb_alu.sv
// combinational rotate and subtract-with-borrow unit
`timescale 1ns/1ps
module rrsb_alu (
  input wire logic [2:0] op,
  input wire logic [7:0] mem_byte,
  input wire logic [7:0] work_in,
  input wire logic [5:0] flags_in,
  output logic [7:0] result,
  output logic work_we,
  output logic mem_we,
  output logic [5:0] flags_out
);
  logic [6:0] shifted;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic carry_in;
  logic wrap;

  assign carry_in = flags_in[rrsb_pkg::FLG_CARRY];

  // ==========================================================
  // right shift by one, the fill bit is chosen per operation
  genvar i;
  generate
    for (i = 0; i < 7; i++)
    begin : g_shift
      assign shifted[i] = mem_byte[i+1];
    end
  endgenerate

  // nine bits so the top bit is the borrow out; low byte is the wrapped result
  assign diff = {1'b0, work_in} - {1'b0, mem_byte} - {8'h00, ~carry_in};
  assign low_diff = {1'b0, work_in[3:0]} - {1'b0, mem_byte[3:0]} - {4'h0, ~carry_in};
  assign wrap = (work_in[7] ^ mem_byte[7]) & (work_in[7] ^ diff[7]);

  // ==========================================================
  // operation select
  always_comb
  begin
    result = work_in;
    work_we = 1'b0;
    mem_we = 1'b0;
    flags_out = flags_in;
    case (op)
      rrsb_pkg::OP_ROT_WORK:
      begin
        result = {mem_byte[0], shifted};
        work_we = 1'b1;
      end
      rrsb_pkg::OP_ROTB_MEM:
      begin
        result = {carry_in, shifted};
        mem_we = 1'b1;
        flags_out[rrsb_pkg::FLG_CARRY] = mem_byte[0];
      end
      rrsb_pkg::OP_ROTB_WORK:
      begin
        result = {carry_in, shifted};
        work_we = 1'b1;
        flags_out[rrsb_pkg::FLG_CARRY] = mem_byte[0];
      end
      rrsb_pkg::OP_SUBB_WORK, rrsb_pkg::OP_SUBB_MEM:
      begin
        result = diff[7:0];
        work_we = (op == rrsb_pkg::OP_SUBB_WORK);
        mem_we = (op == rrsb_pkg::OP_SUBB_MEM);
        flags_out[rrsb_pkg::FLG_CARRY] = ~diff[8];
        flags_out[rrsb_pkg::FLG_ZERO] = (diff[7:0] == 8'h00);
        flags_out[rrsb_pkg::FLG_NIBBLE] = ~low_diff[4];
        flags_out[rrsb_pkg::FLG_WRAP] = wrap;
        flags_out[rrsb_pkg::FLG_SIGN] = wrap ^ diff[7];
        flags_out[rrsb_pkg::FLG_CHAIN] = (diff[7:0] == 8'h00)
          & flags_in[rrsb_pkg::FLG_ZERO];
      end
      default:
      begin
        result = work_in;
      end
    endcase
  end
endmodule

// >>> rrsb_top.sv
// AHB-Lite slave wrapping the rotate/subtract datapath, its registers and data memory
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module rrsb_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  logic pend_r;
  logic wr_r;
  logic size_ok_r;
  logic [7:0] adr_r;
  rrsb_pkg::rrsb_state_t st_r;
  rrsb_pkg::rrsb_state_t st_nxt;
  logic [7:0] work_r;
  logic [5:0] flags_r;
  logic [3:0] maddr_r;
  logic [3:0] xaddr_r;
  logic [2:0] op_r;
  logic [2:0] last_op_r;
  logic idle_act;
  logic do_wr;
  logic cmd_go;
  logic mdat_wr;
  logic mdat_rd;
  logic exec;
  logic done;
  logic accept;
  logic [3:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wd;
  logic [7:0] mem_q;
  logic [7:0] alu_res;
  logic alu_work_we;
  logic alu_mem_we;
  logic [5:0] alu_flags;
  logic [31:0] rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ==========================================================
  // transfer decode
  assign accept = hsel & htrans[1] & hready;
  assign idle_act = (st_r == rrsb_pkg::ST_IDLE) & pend_r;
  assign do_wr = idle_act & wr_r & size_ok_r;
  assign cmd_go = do_wr & hit(adr_r, rrsb_pkg::OFS_CMD);
  assign mdat_wr = do_wr & hit(adr_r, rrsb_pkg::OFS_MDATA);
  assign mdat_rd = idle_act & ~wr_r & hit(adr_r, rrsb_pkg::OFS_MDATA);
  assign exec = (st_r == rrsb_pkg::ST_EXEC);
  assign done = (idle_act & ~cmd_go & ~mdat_rd) | (st_r == rrsb_pkg::ST_MEMRD) | exec;

  // ==========================================================
  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      size_ok_r <= 1'b0;
      adr_r <= 8'h00;
    end
    else if (accept)
    begin
      pend_r <= 1'b1;
      wr_r <= hwrite;
      size_ok_r <= (hsize == rrsb_pkg::HSIZE_WORD);
      adr_r <= haddr[7:0];
    end
    else if (done)
    begin
      pend_r <= 1'b0;
    end
  end

  // every data phase gets wait states until the work is finished
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
    end
    else if (accept)
    begin
      hreadyout <= 1'b0;
    end
    else if (done)
    begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    st_nxt = rrsb_pkg::ST_IDLE;
    case (st_r)
      rrsb_pkg::ST_IDLE:
      begin
        if (cmd_go)
        begin
          st_nxt = rrsb_pkg::ST_EXEC;
        end
        else if (mdat_rd)
        begin
          st_nxt = rrsb_pkg::ST_MEMRD;
        end
      end
      rrsb_pkg::ST_MEMRD:
      begin
        st_nxt = rrsb_pkg::ST_IDLE;
      end
      rrsb_pkg::ST_EXEC:
      begin
        st_nxt = rrsb_pkg::ST_IDLE;
      end
      default:
      begin
        st_nxt = rrsb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= rrsb_pkg::ST_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // command latch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_r <= rrsb_pkg::OP_NONE;
      xaddr_r <= rrsb_pkg::MADDR_RST;
    end
    else if (cmd_go)
    begin
      op_r <= hwdata[rrsb_pkg::CMD_OP_LSB +: rrsb_pkg::CMD_OP_W];
      xaddr_r <= hwdata[rrsb_pkg::CMD_ADDR_LSB +: rrsb_pkg::MEM_AW];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_op_r <= rrsb_pkg::OP_NONE;
    end
    else if (exec)
    begin
      last_op_r <= op_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      maddr_r <= rrsb_pkg::MADDR_RST;
    end
    else if (do_wr && hit(adr_r, rrsb_pkg::OFS_MADDR))
    begin
      maddr_r <= hwdata[rrsb_pkg::MEM_AW-1:0];
    end
  end

  // ==========================================================
  // datapath and memory
  // operand read is issued while the command word is on hwdata
  assign mem_addr = exec ? xaddr_r
                  : (cmd_go ? hwdata[rrsb_pkg::CMD_ADDR_LSB +: rrsb_pkg::MEM_AW] : maddr_r);
  assign mem_we = mdat_wr | (exec & alu_mem_we);
  assign mem_wd = exec ? alu_res : hwdata[7:0];

  rrsb_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wd),
    .rdata(mem_q)
  );

  rrsb_alu u_alu (
    .op(op_r),
    .mem_byte(mem_q),
    .work_in(work_r),
    .flags_in(flags_r),
    .result(alu_res),
    .work_we(alu_work_we),
    .mem_we(alu_mem_we),
    .flags_out(alu_flags)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      work_r <= rrsb_pkg::WORK_RST;
    end
    else if (do_wr && hit(adr_r, rrsb_pkg::OFS_WORK))
    begin
      work_r <= hwdata[7:0];
    end
    else if (exec && alu_work_we)
    begin
      work_r <= alu_res;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags_r <= rrsb_pkg::FLAGS_RST;
    end
    else if (do_wr && hit(adr_r, rrsb_pkg::OFS_FLAGS))
    begin
      flags_r <= hwdata[5:0];
    end
    else if (exec)
    begin
      flags_r <= alu_flags;
    end
  end

  // ==========================================================
  // read data
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (adr_r)
      rrsb_pkg::OFS_CMD: rd_mux = {24'h00_0000, xaddr_r, 1'b0, op_r};
      rrsb_pkg::OFS_WORK: rd_mux = {24'h00_0000, work_r};
      rrsb_pkg::OFS_FLAGS: rd_mux = {26'h000_0000, flags_r};
      rrsb_pkg::OFS_MADDR: rd_mux = {28'h000_0000, maddr_r};
      rrsb_pkg::OFS_STATUS: rd_mux = {29'h0000_0000, last_op_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (st_r == rrsb_pkg::ST_MEMRD)
    begin
      hrdata <= {24'h00_0000, mem_q};
    end
    else if (idle_act && !wr_r)
    begin
      hrdata <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  logic [7:0] chk_q_r;
  logic [7:0] chk_w_r;
  logic [5:0] chk_f_r;
  logic [8:0] ref_diff;
  logic [8:0] ref_sub;
  logic is_sub;
  logic is_rot;

  always_ff @(posedge hclk)
  begin
    chk_q_r <= mem_q;
    chk_w_r <= work_r;
    chk_f_r <= flags_r;
  end

  assign ref_diff = {1'b0, chk_w_r} - {1'b0, chk_q_r} - {8'h00, ~chk_f_r[0]};
  assign ref_sub = {1'b0, chk_q_r} + {8'h00, ~chk_f_r[0]};
  assign is_sub = (op_r == rrsb_pkg::OP_SUBB_WORK) | (op_r == rrsb_pkg::OP_SUBB_MEM);
  assign is_rot = (op_r == rrsb_pkg::OP_ROT_WORK) | (op_r == rrsb_pkg::OP_ROTB_MEM)
                | (op_r == rrsb_pkg::OP_ROTB_WORK);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rot_work_a: assert property (exec && op_r == rrsb_pkg::OP_ROT_WORK |-> !mem_we ##1
    (work_r == {chk_q_r[0], chk_q_r[7:1]}) && (flags_r == chk_f_r))
    else $error("rotate to work result or flags wrong");
  rotb_mem_a: assert property (exec && op_r == rrsb_pkg::OP_ROTB_MEM |-> mem_we
    && (mem_wd == {flags_r[0], mem_q[7:1]}) ##1 (flags_r[0] == chk_q_r[0])
    && (work_r == chk_w_r))
    else $error("carry rotate to memory wrong");
  rotb_work_a: assert property (exec && op_r == rrsb_pkg::OP_ROTB_WORK |-> !mem_we ##1
    (work_r == {chk_f_r[0], chk_q_r[7:1]}) && (flags_r[0] == chk_q_r[0]))
    else $error("carry rotate to work wrong");
  subb_work_a: assert property (exec && op_r == rrsb_pkg::OP_SUBB_WORK |=>
    work_r == ref_diff[7:0])
    else $error("subtract to work result wrong");
  subb_mem_a: assert property (exec && op_r == rrsb_pkg::OP_SUBB_MEM |-> mem_we
    && (mem_wd == 8'(work_r - mem_q - {7'h00, ~flags_r[0]})) ##1 $stable(work_r))
    else $error("subtract to memory wrong");
  borrow_carry_a: assert property (exec && is_sub |=>
    flags_r[0] == ({1'b0, chk_w_r} >= ref_sub))
    else $error("carry after subtract wrong");
  sub_flags_a: assert property (exec && is_sub |=>
    (flags_r[1] == (ref_diff[7:0] == 8'h00)) && (flags_r[5] == (flags_r[1] & chk_f_r[1]))
    && (flags_r[4] == (flags_r[3] ^ ref_diff[7])))
    else $error("subtract flags wrong");
  rot_flags_a: assert property (exec && is_rot |=> flags_r[5:1] == chk_f_r[5:1])
    else $error("rotate touched other flags");
  sub_wrap_a: assert property (exec && op_r == rrsb_pkg::OP_SUBB_WORK |=>
    work_r == 8'(chk_w_r - chk_q_r - {7'h00, ~chk_f_r[0]}))
    else $error("subtract did not wrap to 8 bits");
  bus_done_a: assert property (pend_r && !hreadyout |-> ##[0:2] hreadyout)
    else $error("data phase not finished in time");
endmodule

// >>> tb.sv
// self-checking testbench for the rotate/subtract datapath slice
`timescale 1ns/1ps
module tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int mismatches;
  int check_count;
  int unsigned seed_v;
  logic [2:0] size_v;
  logic [31:0] rd_v;

  // ==========================================================
  // design under test, single slave so hready is its own hreadyout
  rrsb_top rrsb_top_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ==========================================================
  // verdict
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // bus master
  // hready is looked at half a cycle ahead, where it is settled for the coming edge
  task automatic wait_ready(output logic [31:0] data);
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge hclk);
    end
    if (n >= 50)
      mismatches++;
    // data and response are taken at the edge where hready is sampled high
    @(posedge hclk);
    data = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic [31:0] dummy;
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= size_v;
    wait_ready(dummy);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, ofs, wd, dummy);
  endtask

  // ==========================================================
  // reference behaviour: returns {work, memory byte, flags}
  function automatic logic [21:0] model(input logic [2:0] op, input logic [7:0] w,
                                        input logic [7:0] m, input logic [5:0] f);
    logic [7:0] nw;
    logic [7:0] nm;
    logic [5:0] nf;
    logic [8:0] d;
    logic [4:0] h;
    nw = w;
    nm = m;
    nf = f;
    d = {1'b0, w} - {1'b0, m} - {8'h00, ~f[0]};
    h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[0]};
    case (op)
      rrsb_pkg::OP_ROT_WORK: nw = {m[0], m[7:1]};
      rrsb_pkg::OP_ROTB_MEM:
      begin
        nm = {f[0], m[7:1]};
        nf[0] = m[0];
      end
      rrsb_pkg::OP_ROTB_WORK:
      begin
        nw = {f[0], m[7:1]};
        nf[0] = m[0];
      end
      rrsb_pkg::OP_SUBB_WORK, rrsb_pkg::OP_SUBB_MEM:
      begin
        if (op == rrsb_pkg::OP_SUBB_WORK)
          nw = d[7:0];
        else
          nm = d[7:0];
        nf[0] = ~d[8];
        nf[1] = (d[7:0] == 8'h00);
        nf[2] = ~h[4];
        nf[3] = (w[7] ^ m[7]) & (w[7] ^ d[7]);
        nf[4] = nf[3] ^ d[7];
        nf[5] = nf[1] & f[1];
      end
      default: nw = w;
    endcase
    return {nw, nm, nf};
  endfunction

  // ==========================================================
  // one command with fresh operands, then read back every affected register
  task automatic run_op(input logic [2:0] op, input logic [3:0] a, input logic [7:0] m,
                        input logic [7:0] w, input logic [5:0] f);
    logic [21:0] e;
    logic [31:0] d;
    e = model(op, w, m, f);
    wr(rrsb_pkg::OFS_MADDR, {28'h0, a});
    wr(rrsb_pkg::OFS_MDATA, {24'h0, m});
    wr(rrsb_pkg::OFS_WORK, {24'h0, w});
    wr(rrsb_pkg::OFS_FLAGS, {26'h0, f});
    wr(rrsb_pkg::OFS_CMD, {24'h0, a, 1'b0, op});
    bus(1'b0, rrsb_pkg::OFS_WORK, 32'h0, d);
    chk(d, {24'h0, e[21:14]});
    bus(1'b0, rrsb_pkg::OFS_MDATA, 32'h0, d);
    chk(d, {24'h0, e[13:6]});
    bus(1'b0, rrsb_pkg::OFS_FLAGS, 32'h0, d);
    chk(d, {26'h0, e[5:0]});
    bus(1'b0, rrsb_pkg::OFS_STATUS, 32'h0, d);
    chk(d, {29'h0, op});
    bus(1'b0, rrsb_pkg::OFS_CMD, 32'h0, d);
    chk(d, {24'h0, a, 1'b0, op});
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = rrsb_pkg::HSIZE_WORD;
    size_v = rrsb_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    mismatches = 0;
    check_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    seed_v = $urandom(32'h2889);
    run_op(rrsb_pkg::OP_SUBB_WORK, 4'h3, 8'h00, 8'h00, 6'h03);
    run_op(rrsb_pkg::OP_SUBB_WORK, 4'h3, 8'h00, 8'h00, 6'h00);
    run_op(rrsb_pkg::OP_SUBB_MEM, 4'hf, 8'h01, 8'h80, 6'h01);
    run_op(rrsb_pkg::OP_SUBB_MEM, 4'h0, 8'h01, 8'h10, 6'h3f);
    run_op(rrsb_pkg::OP_SUBB_WORK, 4'h9, 8'hff, 8'h7f, 6'h00);
    run_op(rrsb_pkg::OP_ROTB_MEM, 4'h5, 8'h01, 8'h5a, 6'h00);
    run_op(rrsb_pkg::OP_ROTB_MEM, 4'h5, 8'h80, 8'h5a, 6'h3f);
    run_op(rrsb_pkg::OP_ROTB_WORK, 4'h6, 8'h80, 8'h5a, 6'h3f);
    run_op(rrsb_pkg::OP_ROT_WORK, 4'h7, 8'h01, 8'h00, 6'h2a);
    run_op(3'h5, 4'h8, 8'h33, 8'hcc, 6'h15);
    // refused transfers: a byte-sized write is dropped, an unmapped offset reads 0
    wr(rrsb_pkg::OFS_WORK, 32'h0000_005a);
    size_v = 3'b000;
    wr(rrsb_pkg::OFS_WORK, 32'h0000_00a5);
    size_v = rrsb_pkg::HSIZE_WORD;
    bus(1'b0, rrsb_pkg::OFS_WORK, 32'h0, rd_v);
    chk(rd_v, 32'h0000_005a);
    bus(1'b0, 8'h18, 32'h0, rd_v);
    chk(rd_v, 32'h0000_0000);
    for (int i = 0; i < 80; i++)
      run_op(3'($urandom_range(7, 0)), 4'($urandom), 8'($urandom), 8'($urandom),
             6'($urandom));
    end_sim();
  end

  // ==========================================================
  // watchdog, about seven times the expected run
  initial
  begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    end_sim();
  end
endmodule
